/* pkg/icm_pkg.sv */
// package for the capture channel: register map, fields, modes, structs
package icm_pkg;
   // register indices (byte addresses on the plain port)
   localparam logic [7:0] ICM_ADDR_CTRL = 8'h17;
   localparam logic [7:0] ICM_ADDR_CAP_LOW = 8'h15;
   localparam logic [7:0] ICM_ADDR_CAP_HIGH = 8'h16;
   localparam logic [7:0] ICM_ADDR_DUTY_UPPER = 8'h18;
   localparam logic [7:0] ICM_ADDR_FLAG = 8'h19;
   localparam logic [7:0] ICM_ADDR_ENABLE = 8'h1A;
   // reset values
   localparam logic [7:0] ICM_CTRL_RESET = 8'h00;
   localparam logic [7:0] ICM_BYTE_ZERO = 8'h00;
   localparam logic [15:0] ICM_WORD_ZERO = 16'h0000;
   // control field layout
   localparam int ICM_MODE_LSB = 0;
   localparam int ICM_MODE_MSB = 3;
   localparam int ICM_DUTY_ZERO_BIT = 4;
   localparam int ICM_DUTY_ONE_BIT = 5;
   localparam logic [7:0] ICM_CTRL_WMASK = 8'h3F;
   localparam int ICM_FLAG_BIT = 0;
   localparam int ICM_ENABLE_BIT = 0;
   // mode codes
   localparam logic [3:0] ICM_MODE_OFF = 4'h0;
   localparam logic [3:0] ICM_MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] ICM_MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] ICM_MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] ICM_MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] ICM_MODE_CMP_SPECIAL = 4'hB;
   localparam logic [1:0] ICM_CLASS_PWM = 2'h3;
   localparam logic [1:0] ICM_CLASS_CAP = 2'h1;
   // prescaler terminal counts
   localparam logic [3:0] ICM_PS_LAST4 = 4'h3;
   localparam logic [3:0] ICM_PS_LAST16 = 4'hF;
   localparam logic [3:0] ICM_PS_ZERO = 4'h0;
   localparam logic [3:0] ICM_PS_ONE = 4'h1;

   typedef enum logic [1:0] {
      ICM_OFF,
      ICM_CAPTURE,
      ICM_COMPARE,
      ICM_PWM
   } icm_class_t;

   // register-port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } icm_req_t;
endpackage

/* rtl/icm_edge_prescale.sv */
// edge detect and capture-event prescaler for the capture pin
`timescale 1ns/100ps
module icm_edge_prescale
   import icm_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic pin_i,
   input wire logic [3:0] mode_i,
   output logic event_o
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic [3:0] count_q;
   logic [3:0] count_d;
   logic event_d;

   // edges from present and previous synchronized samples
   wire rise = sync2_q & ~prev_q;
   wire fall = ~sync2_q & prev_q;
   wire in_capture = (mode_i[3:2] == ICM_CLASS_CAP);
   wire is_div4 = (mode_i == ICM_MODE_CAP_RISE4);
   wire is_div16 = (mode_i == ICM_MODE_CAP_RISE16);
   wire [3:0] last = is_div16 ? ICM_PS_LAST16 : ICM_PS_LAST4;
   // count wraps on a hit; a switch between capture settings keeps the count
   wire div_hit = (is_div4 | is_div16) & rise & (count_q >= last);

   always_comb begin
      count_d = count_q;
      event_d = 1'b0;
      if (!in_capture) begin
         count_d = ICM_PS_ZERO;
      end else begin
         case (mode_i)
            ICM_MODE_CAP_FALL: event_d = fall;
            ICM_MODE_CAP_RISE: event_d = rise;
            default: begin
               event_d = div_hit;
               if (div_hit) begin
                  count_d = ICM_PS_ZERO;
               end else if (rise) begin
                  count_d = count_q + ICM_PS_ONE;
               end
            end
         endcase
      end
   end

   // two-stage synchronizer, then history and counter
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         count_q <= ICM_PS_ZERO;
         event_o <= 1'b0;
      end else if (ce_i) begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         count_q <= count_d;
         event_o <= event_d;
      end
   end
endmodule

/* rtl/icm_capture_unit.sv */
// capture channel top: control register, capture value, flag, pin, duty
`timescale 1ns/100ps
// How it works
// - low four control bits pick off/reset, capture, compare or PWM operation.
// - in PWM, control bits five/four are duty LSBs under the upper duty byte.
// - a capture event copies the whole 16-bit timer count into the capture bytes.
// - event choices: each falling, each rising, every 4th or 16th rising edge.
// - each capture sets the flag; only software clears it.
// - a new capture silently overwrites an unread captured value.
// - a driven pin whose data write changes the level counts as an edge.
// - mode changes may falsely set the flag; software masks and clears it.
// - prescaler count held at zero when off, outside capture, and after reset.
// - switching between capture prescalers keeps the count; early capture possible.
// - special-event compare match pulses a timer reset, and a converter start only while the converter is enabled.
module icm_capture_unit
   import icm_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [15:0] timer_count_i,
   input wire logic pin_in_i,
   input wire logic pin_dir_input_i,
   input wire logic pin_data_latch_i,
   input wire logic converter_enabled_i,
   output logic flag_o,
   output logic irq_o,
   output logic timer_reset_o,
   output logic convert_start_o,
   output logic [9:0] duty_o
);
   icm_req_t req;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [15:0] capture_q;
   logic [15:0] capture_d;
   logic [7:0] duty_upper_q;
   logic flag_q;
   logic flag_d;
   logic irq_enable_q;
   logic [7:0] rdata_d;
   logic [9:0] duty_d;
   logic cap_event;
   icm_class_t unit_class;

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // address decode
   wire wr_ctrl = req.wr & (req.addr == ICM_ADDR_CTRL);
   wire wr_cap_low = req.wr & (req.addr == ICM_ADDR_CAP_LOW);
   wire wr_cap_high = req.wr & (req.addr == ICM_ADDR_CAP_HIGH);
   wire wr_duty = req.wr & (req.addr == ICM_ADDR_DUTY_UPPER);
   wire wr_flag = req.wr & (req.addr == ICM_ADDR_FLAG);
   wire wr_enable = req.wr & (req.addr == ICM_ADDR_ENABLE);

   // mode field decode
   wire [3:0] unit_mode_select = ctrl_q[ICM_MODE_MSB:ICM_MODE_LSB];
   wire duty_bit_one = ctrl_q[ICM_DUTY_ONE_BIT];
   wire duty_bit_zero = ctrl_q[ICM_DUTY_ZERO_BIT];
   always_comb begin
      case (unit_mode_select[3:2])
         ICM_CLASS_CAP: unit_class = ICM_CAPTURE;
         ICM_CLASS_PWM: unit_class = ICM_PWM;
         default: unit_class = (unit_mode_select[3]) ? ICM_COMPARE : ICM_OFF;
      endcase
   end
   wire capture_mode = (unit_class == ICM_CAPTURE);
   wire pwm_mode = (unit_class == ICM_PWM);

   // pin level seen by the edge logic: driven latch when an output
   wire pin_level = pin_dir_input_i ? pin_in_i : pin_data_latch_i;

   icm_edge_prescale u_edge (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .pin_i(pin_level),
      .mode_i(unit_mode_select),
      .event_o(cap_event)
   );

   // a fresh event only counts while still in capture mode
   wire do_capture = cap_event & capture_mode;

   // compare special event: match on the held value
   wire special_mode = (unit_mode_select == ICM_MODE_CMP_SPECIAL);
   wire special_match = special_mode & (timer_count_i == capture_q);

   // control register: reserved bits stay zero
   assign ctrl_d = wr_ctrl ? (req.wdata & ICM_CTRL_WMASK) : ctrl_q;

   // capture value: hardware copy overwrites, else software byte writes, high byte outside PWM only
   always_comb begin
      capture_d = capture_q;
      if (do_capture) begin
         capture_d = timer_count_i;
      end else if (wr_cap_low) begin
         capture_d[7:0] = req.wdata;
      end else if (wr_cap_high && !pwm_mode) begin
         capture_d[15:8] = req.wdata;
      end
   end

   // flag: set wins over the software clear
   always_comb begin
      flag_d = flag_q;
      if (wr_flag && !req.wdata[ICM_FLAG_BIT]) begin
         flag_d = 1'b0;
      end
      if (do_capture || special_match) begin
         flag_d = 1'b1;
      end
   end

   // ten-bit duty only meaningful in PWM; forced zero elsewhere
   assign duty_d = pwm_mode ? {duty_upper_q, duty_bit_one, duty_bit_zero} : 10'h000;

   // read mux, unmapped reads give zero
   always_comb begin
      case (req.addr)
         ICM_ADDR_CTRL: rdata_d = ctrl_q;
         ICM_ADDR_CAP_LOW: rdata_d = capture_q[7:0];
         ICM_ADDR_CAP_HIGH: rdata_d = capture_q[15:8];
         ICM_ADDR_DUTY_UPPER: rdata_d = duty_upper_q;
         ICM_ADDR_FLAG: rdata_d = {7'h00, flag_q};
         ICM_ADDR_ENABLE: rdata_d = {7'h00, irq_enable_q};
         default: rdata_d = ICM_BYTE_ZERO;
      endcase
   end

   // control register; reserved bits already masked in ctrl_d
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= ICM_CTRL_RESET;
      end else if (ce_i) begin
         ctrl_q <= ctrl_d;
      end
   end

   // capture value holds until the next capture or byte write
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         capture_q <= ICM_WORD_ZERO;
      end else if (ce_i) begin
         capture_q <= capture_d;
      end
   end

   // upper duty byte, only software writes it
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         duty_upper_q <= ICM_BYTE_ZERO;
      end else if (ce_i && wr_duty) begin
         duty_upper_q <= req.wdata;
      end
   end

   // event flag; flag_d already settles set against clear
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_q <= 1'b0;
      end else if (ce_i) begin
         flag_q <= flag_d;
      end
   end

   // interrupt enable bit, only software writes it
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_enable_q <= 1'b0;
      end else if (ce_i && wr_enable) begin
         irq_enable_q <= req.wdata[ICM_ENABLE_BIT];
      end
   end

   // read reply for one cycle only, zero otherwise so idle cycles never leak data
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= ICM_BYTE_ZERO;
      end else if (ce_i) begin
         rdata_o <= req.rd ? rdata_d : ICM_BYTE_ZERO;
      end
   end

   // flag mirror launched from flag_d so it moves on the same edge as flag_q
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_o <= 1'b0;
      end else if (ce_i) begin
         flag_o <= flag_d;
      end
   end

   // software owns the enable; mode changes should happen with it low
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= flag_d & irq_enable_q;
      end
   end

   // special-event trigger, one pulse per matching cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_reset_o <= 1'b0;
      end else if (ce_i) begin
         timer_reset_o <= special_match;
      end
   end

   // converter start gated here, so a disabled converter never sees a pulse
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         convert_start_o <= 1'b0;
      end else if (ce_i) begin
         convert_start_o <= special_match & converter_enabled_i;
      end
   end

   // duty out; zero outside PWM so a stale value never reaches the generator
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         duty_o <= 10'h000;
      end else if (ce_i) begin
         duty_o <= duty_d;
      end
   end
endmodule

/* bench/icm_assertions.sv */
// port assertions for the capture channel
`timescale 1ns/100ps
module icm_assertions
   import icm_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic pin_in_i,
   input wire logic [7:0] rdata_o,
   input wire logic flag_o,
   input wire logic irq_o,
   input wire logic timer_reset_o,
   input wire logic convert_start_o,
   input wire logic [9:0] duty_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic [3:0] mode_q;
   wire ctrl_wr = wr_i && addr_i == ICM_ADDR_CTRL;
   // shadow of the mode field, only software changes it
   always_ff @(posedge clock_i or negedge rstn_i)
      if (!rstn_i) mode_q <= ICM_MODE_OFF;
      else if (ctrl_wr) mode_q <= wdata_i[3:0];
   a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside reply slot");
   // the clear strobe is sampled one edge before the mirror shows the drop
   a_flag_sw_clear: assert property ($fell(flag_o) |-> $past(wr_i) && $past(addr_i) == ICM_ADDR_FLAG
      && !$past(wdata_i[ICM_FLAG_BIT]))
      else $error("flag dropped without a clear");
   a_irq_needs_flag: assert property (irq_o |-> flag_o)
      else $error("irq without flag");
   a_duty_not_pwm: assert property (ctrl_wr && wdata_i[3:2] != 2'b11 |=> ##1 duty_o == 10'h000)
      else $error("duty outside pwm");
   a_duty_low_bits: assert property (ctrl_wr && wdata_i[3:2] == 2'b11 |=> ##1 duty_o[1:0] == $past(wdata_i[5:4], 2))
      else $error("duty low bits wrong");
   a_trigger_convert: assert property (convert_start_o |-> timer_reset_o)
      else $error("convert start without trigger");
   a_rise_capture: assert property (mode_q == ICM_MODE_CAP_RISE && $rose(pin_in_i) |-> ##[4:6] flag_o)
      else $error("rising edge missed");
   a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |-> rdata_o == 8'h00 && !flag_o && duty_o == 10'h000)
      else $error("outputs busy in reset");
endmodule

/* bench/icm_pin_source.sv */
// stand-in for the signal source on the capture pin
`timescale 1ns/100ps
module icm_pin_source (
   input wire logic clock_i,
   output logic pin_o
);
   initial pin_o = 1'b0;
   // each level is held at least two edges so no edge is lost
   task automatic drive(input logic lvl, input int hold);
      pin_o <= lvl;
      repeat (hold < 2 ? 2 : hold) @(posedge clock_i);
   endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the capture channel
`timescale 1ns/100ps
module testbench;
   import icm_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b1;
   icm_req_t req = '0;
   logic [15:0] timer = 16'h0000;
   logic dir = 1'b1, latch = 1'b0, rd_take = 1'b0, trig_seen = 1'b0;
   logic conv_en = 1'b0, conv_seen = 1'b0;
   logic pin, flag_o, irq_o, timer_reset_o, convert_start_o;
   logic [7:0] rdata_o;
   logic [9:0] duty_o;
   logic [15:0] t, u;
   logic [7:0] exp_q[$];
   int fail_count = 0, checked = 0;
   always #2 clock_i = ~clock_i;
   icm_pin_source u_src (.clock_i(clock_i), .pin_o(pin));
   icm_capture_unit u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .addr_i(req.addr),
      .wdata_i(req.wdata), .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata_o), .timer_count_i(timer),
      .pin_in_i(pin), .pin_dir_input_i(dir), .pin_data_latch_i(latch), .converter_enabled_i(conv_en),
      .flag_o(flag_o), .irq_o(irq_o), .timer_reset_o(timer_reset_o), .convert_start_o(convert_start_o),
      .duty_o(duty_o));
   task automatic chk(input string nm, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // each bus op takes two edges, so strobes never toggle twice at once
   task automatic wr(input logic [7:0] a, d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_i);
      req <= '0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_i);
      req <= '0;
      @(posedge clock_i);
   endtask
   task automatic edge_at(input logic lvl, input logic [15:0] tv);
      timer <= tv;
      u_src.drive(lvl, 8);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clock_i) begin
      rd_take <= req.rd;
      if (timer_reset_o === 1'b1) trig_seen <= 1'b1;
      if (convert_start_o === 1'b1) conv_seen <= 1'b1;
   end
   // reply is settled by the falling edge after the read edge
   always @(negedge clock_i)
      if (rd_take && exp_q.size() > 0) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
   initial begin
      // reset edge at time zero so the outputs are defined before the first clock
      rstn_i <= 1'b0;
      void'($urandom(31213));
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      rd(ICM_ADDR_CTRL, ICM_CTRL_RESET);
      rd(8'h00, ICM_BYTE_ZERO);
      wr(ICM_ADDR_CTRL, 8'hFF);
      rd(ICM_ADDR_CTRL, ICM_CTRL_WMASK);
      wr(ICM_ADDR_DUTY_UPPER, 8'hA5);
      wr(ICM_ADDR_CTRL, 8'h2C);
      @(negedge clock_i);
      chk("duty", 16'h0296, {6'h00, duty_o});
      @(posedge clock_i);
      wr(ICM_ADDR_CTRL, 8'h35);
      @(negedge clock_i);
      chk("duty", 16'h0000, {6'h00, duty_o});
      @(posedge clock_i);
      $display("test registers done");
      wr(ICM_ADDR_ENABLE, 8'h01);
      // falling then rising: only the chosen edge may capture
      for (int k = 4; k < 6; k++) begin
         t = 16'($urandom());
         u = ~t;
         wr(ICM_ADDR_ENABLE, 8'h00);
         wr(ICM_ADDR_CTRL, 8'h00);
         wr(ICM_ADDR_CTRL, 8'(k));
         wr(ICM_ADDR_FLAG, 8'h00);
         wr(ICM_ADDR_ENABLE, 8'h01);
         edge_at(1'b1, t);
         edge_at(1'b0, u);
         rd(ICM_ADDR_CAP_LOW, k == 4 ? u[7:0] : t[7:0]);
         rd(ICM_ADDR_CAP_HIGH, k == 4 ? u[15:8] : t[15:8]);
         chk("irq", 16'h0001, {15'h0000, irq_o});
         chk("flag", 16'h0001, {15'h0000, flag_o});
      end
      t = 16'($urandom());
      edge_at(1'b1, u);
      edge_at(1'b0, u);
      edge_at(1'b1, t);
      edge_at(1'b0, t);
      rd(ICM_ADDR_CAP_LOW, t[7:0]);
      rd(ICM_ADDR_CAP_HIGH, t[15:8]);
      $display("test single edges done");
      for (int k = 6; k < 8; k++) begin
         wr(ICM_ADDR_CTRL, 8'h00);
         wr(ICM_ADDR_CTRL, 8'(k));
         wr(ICM_ADDR_FLAG, 8'h00);
         for (int n = 1; n <= (k == 6 ? 4 : 16); n++) begin
            if (n == (k == 6 ? 4 : 16)) rd(ICM_ADDR_FLAG, ICM_BYTE_ZERO);
            t = 16'($urandom());
            edge_at(1'b1, t);
            edge_at(1'b0, t);
         end
         rd(ICM_ADDR_FLAG, 8'h01);
         rd(ICM_ADDR_CAP_LOW, t[7:0]);
      end
      // direct switch 4 to 16 keeps two counted edges
      wr(ICM_ADDR_CTRL, 8'h00);
      wr(ICM_ADDR_CTRL, 8'h06);
      wr(ICM_ADDR_FLAG, 8'h00);
      for (int n = 1; n <= 16; n++) begin
         if (n == 3) wr(ICM_ADDR_CTRL, 8'h07);
         if (n == 16) rd(ICM_ADDR_FLAG, ICM_BYTE_ZERO);
         edge_at(1'b1, t);
         edge_at(1'b0, t);
      end
      rd(ICM_ADDR_FLAG, 8'h01);
      $display("test prescaler done");
      dir <= 1'b0;
      wr(ICM_ADDR_CTRL, 8'h05);
      wr(ICM_ADDR_FLAG, 8'h00);
      latch <= 1'b1;
      repeat (8) @(posedge clock_i);
      rd(ICM_ADDR_FLAG, 8'h01);
      dir <= 1'b1;
      // three counted edges, then off: the count must not survive
      wr(ICM_ADDR_CTRL, 8'h06);
      wr(ICM_ADDR_FLAG, 8'h00);
      repeat (3) begin
         edge_at(1'b1, t);
         edge_at(1'b0, t);
      end
      wr(ICM_ADDR_CTRL, 8'h00);
      edge_at(1'b1, t);
      edge_at(1'b0, t);
      rd(ICM_ADDR_FLAG, ICM_BYTE_ZERO);
      wr(ICM_ADDR_CTRL, 8'h06);
      edge_at(1'b1, t);
      edge_at(1'b0, t);
      rd(ICM_ADDR_FLAG, ICM_BYTE_ZERO);
      $display("test pin and off done");
      wr(ICM_ADDR_CAP_LOW, t[7:0]);
      wr(ICM_ADDR_CAP_HIGH, t[15:8]);
      wr(ICM_ADDR_CTRL, 8'h0B);
      repeat (4) @(posedge clock_i);
      chk("trigger", 16'h0001, {15'h0000, trig_seen});
      chk("convert", 16'h0000, {15'h0000, conv_seen});
      conv_en <= 1'b1;
      repeat (4) @(posedge clock_i);
      chk("convert", 16'h0001, {15'h0000, conv_seen});
      $display("test special event done");
      wrap_up();
   end
endmodule
bind icm_capture_unit icm_assertions u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .pin_in_i(pin_in_i), .rdata_o(rdata_o), .flag_o(flag_o),
   .irq_o(irq_o), .timer_reset_o(timer_reset_o), .convert_start_o(convert_start_o), .duty_o(duty_o));
